// ### tc_timer16.sv
// Top module: 16-bit timer/counter with Avalon-MM register slave
`timescale 1ns/1ps
module tc_timer16
  import tc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Count sources
  input wire logic i_ext_count_pin,
  input wire logic i_xtal_in_pin,
  output logic o_xtal_out_pin,
  // System state and compare units
  input wire logic i_sleep,
  input wire logic i_sevt_compare_unit_a,
  input wire logic i_sevt_compare_unit_b,
  // Status towards the rest of the chip
  output logic [15:0] o_count,
  output logic o_timebase_valid,
  output logic o_overflow_flag
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ack;
  tc_ctrl_s ctrl;
  logic [15:0] count;
  logic ovf_flag;

  wire req = i_avs_read | i_avs_write;
  wire take = req & ack;
  wire wr_ctrl = take & i_avs_write & (i_avs_address == TC_ADDR_CTRL);
  wire wr_low = take & i_avs_write & (i_avs_address == TC_ADDR_LOW);
  wire wr_high = take & i_avs_write & (i_avs_address == TC_ADDR_HIGH);
  wire wr_flag = take & i_avs_write & (i_avs_address == TC_ADDR_FLAG);
  wire wr_count = wr_low | wr_high;

  // One wait cycle gives the read mux a clean registered snapshot
  assign o_avs_waitrequest = req & ~ack;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  logic [31:0] next_rdata;

  // Count bytes read from one flop copy, so a byte is never torn [RULE_08]
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_avs_address)
      TC_ADDR_CTRL: next_rdata = {26'h000_0000, ctrl};
      TC_ADDR_LOW: next_rdata = {24'h00_0000, count[7:0]};
      TC_ADDR_HIGH: next_rdata = {24'h00_0000, count[15:8]};
      TC_ADDR_FLAG: next_rdata = {31'h0000_0000, ovf_flag};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read & ~ack) begin
      o_avs_readdata <= next_rdata;
    end
  end

  // Reset input stands for power-on and brown-out reset [RULE_19]
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= TC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= i_avs_writedata[5:0];
    end
  end

  // ----------------------------------------
  // Crystal oscillator and source select
  // ----------------------------------------
  // Amplifier is off while disabled to save power; runs in sleep too [RULE_11]
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_xtal_out_pin <= 1'b0;
    end else begin
      o_xtal_out_pin <= ctrl.crystal_osc_enable & ~i_xtal_in_pin;
    end
  end

  wire sel_in = ctrl.crystal_osc_enable ? i_xtal_in_pin : i_ext_count_pin; // [RULE_02]

  logic sel_prev;
  wire sel_rise = sel_in & ~sel_prev;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Ripple-style divider, advanced by input edges (keeps going in sleep) or by Q4 ticks in timer mode
  logic [2:0] psc;
  logic psc_prev;
  logic psc_out;
  // One step per selected input edge, or per Q4 in timer mode
  logic psc_step;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev <= 1'b0;
      psc <= 3'h0;
      psc_prev <= 1'b0;
    end else begin
      sel_prev <= sel_in;
      psc_prev <= psc_out;
      if (wr_count) begin
        psc <= 3'h0; // [RULE_20]
      end else if (psc_step) begin
        psc <= psc + 3'h1; // [RULE_03] [RULE_04]
      end
    end
  end

  always_comb begin
    case (ctrl.prescale_select) // [RULE_22]
      2'h0: psc_out = sel_in;
      2'h1: psc_out = psc[0];
      2'h2: psc_out = psc[1];
      2'h3: psc_out = psc[2];
      default: psc_out = sel_in;
    endcase
  end

  // ----------------------------------------
  // Phase clock and synchronizer
  // ----------------------------------------
  tc_phase_e phase;
  tc_phase_e next_phase;

  always_comb begin
    case (phase)
      TC_Q1: next_phase = TC_Q2;
      TC_Q2: next_phase = TC_Q3;
      TC_Q3: next_phase = TC_Q4;
      TC_Q4: next_phase = TC_Q1;
      default: next_phase = TC_Q1;
    endcase
  end

  // Phase clocks stop in sleep, which shuts the synchronizer off
  wire sample_pt = ~i_sleep & ((phase == TC_Q2) | (phase == TC_Q4)); // [RULE_05]
  logic samp;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase <= TC_Q1;
      samp <= 1'b0;
    end else begin
      if (!i_sleep) begin
        phase <= next_phase;
      end
      if (sample_pt) begin
        samp <= psc_out; // [RULE_03]
      end
    end
  end

  // ----------------------------------------
  // Count selection
  // ----------------------------------------
  wire async_mode = ctrl.clock_source_select & ctrl.sync_disable;
  wire q4_tick = ~i_sleep & (phase == TC_Q4); // [RULE_01]
  // Timer mode divides the Q4 tick by the same prescaler: carry out of the selected bits
  wire [2:0] psc_mask = {ctrl.prescale_select == 2'h3, ctrl.prescale_select[1],
    |ctrl.prescale_select};
  wire timer_tick = q4_tick & ((psc & psc_mask) == psc_mask); // [RULE_22]
  assign psc_step = ctrl.clock_source_select ? sel_rise : q4_tick;
  wire sync_tick = sample_pt & psc_out & ~samp; // [RULE_04] [RULE_05]
  wire async_tick = psc_out & ~psc_prev; // [RULE_06]

  wire ext_tick = ctrl.sync_disable ? async_tick : sync_tick;
  wire src_tick = ctrl.clock_source_select ? ext_tick : timer_tick; // [RULE_01] [RULE_02]
  wire tick = ctrl.timer_on & src_tick; // [RULE_21]

  // Trigger is dropped in async mode, where it is not guaranteed anyway
  wire sevt = (i_sevt_compare_unit_a | i_sevt_compare_unit_b) & ~async_mode; // [RULE_13] [RULE_15]
  wire wrap = tick & (count == TC_COUNT_MAX) & ~wr_count & ~sevt; // [RULE_14] [RULE_21]

  // ----------------------------------------
  // Counter and overflow flag
  // ----------------------------------------
  // No reset on purpose: device resets leave the count alone [RULE_18]
  always_ff @(posedge i_clk_sys) begin
    if (wr_count) begin
      if (wr_low) begin
        count[7:0] <= i_avs_writedata[7:0]; // [RULE_16]
      end
      if (wr_high) begin
        count[15:8] <= i_avs_writedata[7:0]; // [RULE_16]
      end
    end else if (sevt) begin
      count <= TC_COUNT_ZERO; // [RULE_13] [RULE_17]
    end else if (tick) begin
      count <= count + 16'h0001; // [RULE_21]
    end
  end

  // Write one to clear; a wrap in the same cycle still sets the flag
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag <= 1'b0;
    end else if (wrap) begin
      ovf_flag <= 1'b1; // [RULE_06] [RULE_21]
    end else if (wr_flag & i_avs_writedata[TC_FLAG_OVF_BIT]) begin
      ovf_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_count = count; // [RULE_17]
  assign o_timebase_valid = ~async_mode; // [RULE_07]
  assign o_overflow_flag = ovf_flag;

endmodule

// ### tc_pkg.sv
// Package with constants and types for the 16-bit timer/counter
//
// Notes on behaviour
// RULE_01 - Source select clear counts instruction clock
// RULE_02 - Source set counts rising edges of selected pin
// RULE_03 - Sync after ripple prescaler when sync enabled
// RULE_04 - Synced counter stops in sleep, prescaler runs
// RULE_05 - Synchronizer samples on phases two and four
// RULE_06 - Async counter runs in sleep, may flag
// RULE_07 - Async count is no capture/compare time base
// RULE_08 - Byte reads return valid values while counting
// RULE_09 - Software stops counter before async writes
// RULE_10 - Software reads high, low, high again
// RULE_11 - Oscillator enable starts crystal amplifier
// RULE_12 - Software waits for oscillator start-up
// RULE_13 - Compare special event trigger zeroes counter
// RULE_14 - Special event reset never sets overflow flag
// RULE_15 - Special event reset ignored in async mode
// RULE_16 - Software write beats simultaneous trigger
// RULE_17 - Compare pair acts as period value
// RULE_18 - Counter bytes untouched by device resets
// RULE_19 - Power-on reset clears control register
// RULE_20 - Counter byte write clears prescaler
// RULE_21 - Counter wraps, flags overflow, needs timer_on
// RULE_22 - Prescale codes divide by 1, 2, 4, 8
package tc_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] TC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] TC_ADDR_LOW = 4'h4;
  localparam logic [3:0] TC_ADDR_HIGH = 4'h8;
  localparam logic [3:0] TC_ADDR_FLAG = 4'hC;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int TC_FLAG_OVF_BIT = 0;
  localparam logic [5:0] TC_CTRL_RESET = 6'h00;
  localparam logic [15:0] TC_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] TC_COUNT_ZERO = 16'h0000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int TC_CLK_HZ = 50000000;
  localparam int TC_XTAL_MAX_HZ = 200000;
  localparam int TC_PHASES = 4;

  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic [1:0] prescale_select;
    logic crystal_osc_enable;
    logic sync_disable;
    logic clock_source_select;
    logic timer_on;
  } tc_ctrl_s;

  // Quarter phases of one instruction cycle
  typedef enum logic [3:0] {
    TC_Q1 = 4'b0001,
    TC_Q2 = 4'b0010,
    TC_Q3 = 4'b0100,
    TC_Q4 = 4'b1000
  } tc_phase_e;

endpackage

// ### tc_timer16_properties.sv
// Checker for the timer/counter bus, count and flag behaviour
`timescale 1ns/1ps
module tc_timer16_properties
  import tc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_xtal_out_pin,
  input wire logic i_sevt_compare_unit_a,
  input wire logic i_sevt_compare_unit_b,
  input wire logic [15:0] o_count,
  input wire logic o_timebase_valid,
  input wire logic o_overflow_flag
);
  // ----------------------------------------
  // Shadow of the control register
  // ----------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic [5:0] ctl;
  wire acc = i_avs_write & ~o_avs_waitrequest;
  wire cnt_wr = acc & (i_avs_address == TC_ADDR_LOW | i_avs_address == TC_ADDR_HIGH);
  wire sevt = i_sevt_compare_unit_a | i_sevt_compare_unit_b;
  wire rd_ok = i_avs_read & ~o_avs_waitrequest;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn)
      ctl <= TC_CTRL_RESET;
    else if (acc && i_avs_address == TC_ADDR_CTRL)
      ctl <= i_avs_writedata[5:0];
  end
  a_bus_one_wait: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1
    !o_avs_waitrequest) else $error("bus wait is not exactly one cycle");
  a_ctrl_read: assert property (rd_ok && i_avs_address == TC_ADDR_CTRL |->
    o_avs_readdata == {26'h0000000, ctl}) else $error("control readback wrong");
  a_timebase_mode: assert property (o_timebase_valid == !(ctl[1] & ctl[2]))
    else $error("time base valid wrong for mode");
  a_xtal_off: assert property (!ctl[3] && !$past(ctl[3]) |-> !o_xtal_out_pin)
    else $error("crystal amplifier active while disabled");
  a_trig_zero: assert property (sevt && o_timebase_valid && !cnt_wr |=>
    o_count == TC_COUNT_ZERO) else $error("trigger did not zero count");
  a_trig_no_flag: assert property (sevt && o_timebase_valid && !o_overflow_flag |=>
    !o_overflow_flag) else $error("trigger set overflow flag");
  a_write_wins: assert property (cnt_wr && sevt && i_avs_address == TC_ADDR_LOW |=>
    o_count[7:0] == $past(i_avs_writedata[7:0])) else $error("trigger beat write");
  a_wrap_flag: assert property ($past(o_count) == TC_COUNT_MAX && o_count == TC_COUNT_ZERO &&
    !$past(i_avs_write) && !$past(sevt) |-> ##[0:1] o_overflow_flag) else $error("no flag on wrap");
endmodule

bind tc_timer16 tc_timer16_properties i_tc_timer16_properties (.i_clk_sys, .i_resetn,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
  .o_avs_waitrequest, .o_xtal_out_pin, .i_sevt_compare_unit_a, .i_sevt_compare_unit_b,
  .o_count, .o_timebase_valid, .o_overflow_flag);

// ### tc_src_model.sv
// External clock source driving the count pin and the crystal input pin
`timescale 1ns/1ps
module tc_src_model (
  // Clock
  input wire logic i_clk_sys,
  // Pins
  output logic o_ext_count_pin,
  output logic o_xtal_in_pin
);
  initial begin
    o_ext_count_pin = 1'b0;
    o_xtal_in_pin = 1'b0;
  end
  // Two clocks high and three low between pulses so that phase sampling sees each edge
  task automatic pulse(input logic xt, input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      o_xtal_in_pin <= xt;
      o_ext_count_pin <= !xt;
      repeat (2) @(posedge i_clk_sys);
      o_xtal_in_pin <= 1'b0;
      o_ext_count_pin <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
    end
  endtask
endmodule

// ### tb_top.sv
// Testbench for the 16-bit timer/counter
`timescale 1ns/1ps
module tb_top;
  import tc_pkg::*;
  // ----------------------------------------
  // Signals, tasks and tests
  // ----------------------------------------
  logic i_clk_sys = 1'b0;
  logic i_resetn, i_avs_read, i_avs_write, i_sleep, i_sevt_compare_unit_a, i_sevt_compare_unit_b;
  logic [3:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, d;
  logic o_avs_waitrequest, o_xtal_out_pin, o_timebase_valid, o_overflow_flag;
  logic i_ext_count_pin, i_xtal_in_pin;
  logic [15:0] o_count, c0;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  tc_timer16 i_tc_timer16 (.*);
  tc_src_model i_tc_src_model (.i_clk_sys(i_clk_sys), .o_ext_count_pin(i_ext_count_pin),
    .o_xtal_in_pin(i_xtal_in_pin));
  initial begin
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_writedata <= {24'h000000, v};
    i_avs_write <= 1'b1;
    do @(negedge i_clk_sys); while (o_avs_waitrequest);
    @(posedge i_clk_sys);
    i_avs_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_read <= 1'b1;
    do @(negedge i_clk_sys); while (o_avs_waitrequest);
    @(posedge i_clk_sys);
    d = o_avs_readdata;
    i_avs_read <= 1'b0;
    chk(d, exp);
  endtask
  // Settle time covers the synchronizer latency after the last edge
  task run_pulses(input logic xt, input int n, input logic [15:0] exp);
    @(negedge i_clk_sys);
    c0 = o_count;
    i_tc_src_model.pulse(xt, n);
    repeat (4) @(negedge i_clk_sys);
    chk({16'h0000, o_count - c0}, {16'h0000, exp});
    @(posedge i_clk_sys);
  endtask
  initial begin
    {i_resetn, i_avs_read, i_avs_write, i_sleep} = 4'h0;
    {i_sevt_compare_unit_a, i_sevt_compare_unit_b, i_avs_address, i_avs_writedata} = '0;
    repeat (5) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    rd(TC_ADDR_CTRL, 32'h0);
    rd(4'h2, 32'h0);
    rd(TC_ADDR_FLAG, 32'h0);
    wr(TC_ADDR_HIGH, 8'h00);
    wr(TC_ADDR_LOW, 8'h00);
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      wr(TC_ADDR_CTRL, {2'b00, 2'(p), 4'h5});
      @(negedge i_clk_sys);
      c0 = o_count;
      repeat (64) @(negedge i_clk_sys);
      chk({16'h0000, o_count - c0}, 32'h10 >> p);
    end
    $display("test timer done");
    wr(TC_ADDR_CTRL, 8'h03);
    run_pulses(1'b0, 5, 16'h0005);
    i_sleep <= 1'b1;
    run_pulses(1'b0, 3, 16'h0000);
    wr(TC_ADDR_CTRL, 8'h07);
    run_pulses(1'b0, 3, 16'h0003);
    i_sleep <= 1'b0;
    wr(TC_ADDR_CTRL, 8'h0F);
    repeat (50) @(posedge i_clk_sys);
    run_pulses(1'b1, 4, 16'h0004);
    run_pulses(1'b0, 2, 16'h0000);
    $display("test counter done");
    wr(TC_ADDR_CTRL, 8'h06);
    wr(TC_ADDR_HIGH, 8'hFF);
    wr(TC_ADDR_LOW, 8'hFE);
    rd(TC_ADDR_HIGH, 32'hFF);
    rd(TC_ADDR_LOW, 32'hFE);
    rd(TC_ADDR_HIGH, 32'hFF);
    run_pulses(1'b0, 3, 16'h0000);
    wr(TC_ADDR_CTRL, 8'h07);
    run_pulses(1'b0, 2, 16'h0002);
    chk({31'h00000000, o_overflow_flag}, 32'h1);
    rd(TC_ADDR_FLAG, 32'h1);
    wr(TC_ADDR_FLAG, 8'h01);
    rd(TC_ADDR_FLAG, 32'h0);
    $display("test wrap done");
    wr(TC_ADDR_CTRL, 8'h06);
    wr(TC_ADDR_LOW, 8'h02);
    i_sevt_compare_unit_b <= 1'b1;
    @(posedge i_clk_sys);
    i_sevt_compare_unit_b <= 1'b0;
    rd(TC_ADDR_LOW, 32'h2);
    wr(TC_ADDR_LOW, 8'h80);
    wr(TC_ADDR_CTRL, 8'h01);
    i_sevt_compare_unit_a <= 1'b1;
    @(posedge i_clk_sys);
    i_sevt_compare_unit_a <= 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk({31'h00000000, o_count < 16'h0003}, 32'h1);
    chk({31'h00000000, o_overflow_flag}, 32'h0);
    wr(TC_ADDR_CTRL, 8'h00);
    i_sevt_compare_unit_a <= 1'b1;
    wr(TC_ADDR_LOW, 8'h55);
    i_sevt_compare_unit_a <= 1'b0;
    @(negedge i_clk_sys);
    chk({16'h0000, o_count}, 32'h55);
    $display("test trigger done");
    give_verdict();
  end
endmodule
